/* rtl/vcd_clock_gen.v */
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Calibration clock from divided reference; needs reference, loop.
// - First calibration: start bit then update.
// - Status bit reads one after calibration completes.
// - Outputs forced into sync during calibration.
// - Release sync, then close the loop.
// - Two-bit field divides detector clock for calibration.
// - Calibration lasts 4400 calibration clock cycles.
// - Never self-start calibration on divider changes.
// - Four channels: two single, two cascaded dividers.
// - Post divider ratios 2 to 6, oscillator path.
// - High N+1, low M+1 input cycles.
// - Disableable duty correction for odd when M=N+1.
// - Coarse phase delay to 31, start level.
// - Two-bit source select; code 11 disallowed.
// - Post divider input routable to first/second pair.
// - Low and high counts are four-bit fields.
`include "vcd_defines.vh"
module vcd_clock_gen #(
  parameter REF_LOSS_CYCLES = `VCD_REF_LOSS_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Clock pins, sampled
  input  wire        reference_input_clock,
  input  wire        ext_clk_in,
  input  wire        osc_clk_in,
  // AXI4-Lite write
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Distribution outputs
  output reg         diff_output_first_a,
  output reg         diff_output_first_b,
  output reg         diff_output_second_a,
  output reg         diff_output_second_b,
  output reg         chan2_out,
  output reg         chan3_out,
  // Loop and calibration state
  output reg         cal_sync_active,
  output reg         loop_closed
);
  localparam NS = 19;
  localparam ST_IDLE  = 2'h0;
  localparam ST_PEND  = 2'h1;
  localparam ST_RUN   = 2'h2;
  localparam ST_CLOSE = 2'h3;

  reg  [7:0]  stg_reg [0:NS-1];
  reg  [7:0]  act_reg [0:NS-1];
  reg  [2:0]  ref_sync_reg;
  reg  [2:0]  ext_sync_reg;
  reg  [2:0]  osc_sync_reg;
  reg  [31:0] ref_age_reg;
  reg         ref_ok_reg;
  reg         aw_have_reg;
  reg         w_have_reg;
  reg  [9:0]  aw_idx_reg;
  reg  [7:0]  w_data_reg;
  reg         w_lane_reg;
  reg         update_reg;
  reg         start_prev_reg;
  reg  [1:0]  state_reg;
  reg  [13:0] rcnt_reg;
  reg  [3:0]  ccnt_reg;
  reg  [12:0] cal_cnt_reg;
  reg         cal_done_reg;
  integer     i;

  // Maps a register index to its storage slot; NS means unmapped.
  function [4:0] slot_of;
    input [9:0] idx;
    begin
      case (idx)
        `VCD_IDX_CAL_CTRL:  slot_of = 5'd0;
        `VCD_IDX_RDIV_LO:   slot_of = 5'd1;
        `VCD_IDX_RDIV_HI:   slot_of = 5'd2;
        `VCD_IDX_LOOP_CTRL: slot_of = 5'd3;
        `VCD_IDX_POST_DIV:  slot_of = 5'd4;
        `VCD_IDX_SRC_SEL:   slot_of = 5'd5;
        `VCD_IDX_ROUTE:     slot_of = 5'd6;
        `VCD_IDX_DIV0_MN:   slot_of = 5'd7;
        `VCD_IDX_DIV0_CTL:  slot_of = 5'd8;
        `VCD_IDX_DIV1_MN:   slot_of = 5'd9;
        `VCD_IDX_DIV1_CTL:  slot_of = 5'd10;
        `VCD_IDX_DIV2A_MN:  slot_of = 5'd11;
        `VCD_IDX_DIV2A_CTL: slot_of = 5'd12;
        `VCD_IDX_DIV2B_MN:  slot_of = 5'd13;
        `VCD_IDX_DIV2B_CTL: slot_of = 5'd14;
        `VCD_IDX_DIV3A_MN:  slot_of = 5'd15;
        `VCD_IDX_DIV3A_CTL: slot_of = 5'd16;
        `VCD_IDX_DIV3B_MN:  slot_of = 5'd17;
        `VCD_IDX_DIV3B_CTL: slot_of = 5'd18;
        default:            slot_of = NS[4:0];
      endcase
    end
  endfunction

  // Pin sampling and edge events.
  wire ref_rise = ref_sync_reg[1] & ~ref_sync_reg[2];
  wire ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];
  wire ext_fall = ~ext_sync_reg[1] & ext_sync_reg[2];
  wire osc_rise = osc_sync_reg[1] & ~osc_sync_reg[2];
  wire osc_fall = ~osc_sync_reg[1] & osc_sync_reg[2];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_sync_reg <= 3'h0;
      ext_sync_reg <= 3'h0;
      osc_sync_reg <= 3'h0;
      ref_age_reg  <= 32'h0;
      ref_ok_reg   <= 1'b0;
    end else begin
      ref_sync_reg <= {ref_sync_reg[1:0], reference_input_clock};
      ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_in};
      osc_sync_reg <= {osc_sync_reg[1:0], osc_clk_in};
      if (ref_rise) begin
        ref_age_reg <= 32'h0;
        ref_ok_reg  <= 1'b1;
      end else if (ref_age_reg >= REF_LOSS_CYCLES - 1) begin
        ref_ok_reg  <= 1'b0;
      end else begin
        ref_age_reg <= ref_age_reg + 32'h1;
      end
    end
  end

  // AXI4-Lite slave; writes land in staged registers.
  wire [4:0] w_slot = slot_of(aw_idx_reg);
  wire [4:0] r_slot = slot_of(s_axi_araddr[11:2]);
  wire       w_do   = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_idx_reg    <= 10'h000;
      w_data_reg    <= 8'h00;
      w_lane_reg    <= 1'b0;
      update_reg    <= 1'b0;
      for (i = 0; i < NS; i = i + 1) begin
        stg_reg[i] <= `VCD_RESET_BYTE;
      end
    end else begin
      update_reg <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg   <= 1'b1;
        aw_idx_reg    <= s_axi_awaddr[11:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata[7:0];
        w_lane_reg   <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (w_do) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        if (aw_idx_reg == `VCD_IDX_UPDATE) begin
          update_reg <= w_lane_reg & w_data_reg[`VCD_UPDATE_BIT];
        end else if (w_slot != NS[4:0]) begin
          if (w_lane_reg)
            stg_reg[w_slot] <= w_data_reg;
        end else if (aw_idx_reg != `VCD_IDX_STATUS) begin
          s_axi_bresp <= 2'h2;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'h0;
        s_axi_rdata   <= 32'h0;
        if (s_axi_araddr[11:2] == `VCD_IDX_STATUS) begin
          s_axi_rdata[`VCD_CAL_DONE_BIT] <= cal_done_reg;
          s_axi_rdata[`VCD_REF_OK_BIT]   <= ref_ok_reg;
        end else if (r_slot != NS[4:0]) begin
          s_axi_rdata[7:0] <= stg_reg[r_slot];
        end else if (s_axi_araddr[11:2] != `VCD_IDX_UPDATE) begin
          s_axi_rresp <= 2'h2;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Update command copies all staged settings to the active set.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < NS; i = i + 1) begin
        act_reg[i] <= (i >= 7 && i[0] == 1'b0) ? `VCD_RESET_CTL : `VCD_RESET_BYTE;
      end
    end else if (update_reg) begin
      for (i = 0; i < NS; i = i + 1) begin
        act_reg[i] <= stg_reg[i];
      end
    end
  end

  // Calibration sequencer.
  wire        cal_start_bit = act_reg[0][`VCD_CAL_START_BIT];
  wire        cal_trigger   = cal_start_bit & ~start_prev_reg;
  wire [1:0]  cal_div_code  = act_reg[0][`VCD_CAL_DIV_LSB +: 2];
  wire [3:0]  cal_div_m1    = (4'h2 << cal_div_code) - 4'h1;
  wire [13:0] rdiv          = {act_reg[2][5:0], act_reg[1]};
  wire [13:0] rdiv_m1       = (rdiv == 14'h0) ? 14'h0 : rdiv - 14'h1;
  wire        loop_en       = act_reg[3][`VCD_LOOP_EN_BIT];
  wire        pfd_tick      = ref_rise && (rcnt_reg == rdiv_m1);
  wire        cal_tick      = pfd_tick && (ccnt_reg == cal_div_m1);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      start_prev_reg  <= 1'b0;
      state_reg       <= ST_IDLE;
      rcnt_reg        <= 14'h0;
      ccnt_reg        <= 4'h0;
      cal_cnt_reg     <= 13'h0;
      cal_done_reg    <= 1'b0;
      cal_sync_active <= 1'b0;
      loop_closed     <= 1'b0;
    end else begin
      start_prev_reg <= cal_start_bit;
      case (state_reg)
        ST_IDLE: begin
          if (cal_trigger) begin
            cal_done_reg    <= 1'b0;
            cal_sync_active <= 1'b1;
            loop_closed     <= 1'b0;
            state_reg       <= ST_PEND;
          end
        end
        ST_PEND: begin
          rcnt_reg    <= 14'h0;
          ccnt_reg    <= 4'h0;
          cal_cnt_reg <= 13'h0;
          if (ref_ok_reg && loop_en)
            state_reg <= ST_RUN;
        end
        ST_RUN: begin
          if (!ref_ok_reg || !loop_en) begin
            state_reg <= ST_PEND;
          end else if (ref_rise) begin
            rcnt_reg <= pfd_tick ? 14'h0 : rcnt_reg + 14'h1;
            if (pfd_tick)
              ccnt_reg <= cal_tick ? 4'h0 : ccnt_reg + 4'h1;
            if (cal_tick) begin
              cal_cnt_reg <= cal_cnt_reg + 13'h1;
              if (cal_cnt_reg == `VCD_CAL_CYCLES - 13'h1) begin
                cal_sync_active <= 1'b0;
                state_reg       <= ST_CLOSE;
              end
            end
          end
        end
        ST_CLOSE: begin
          loop_closed  <= 1'b1;
          cal_done_reg <= 1'b1;
          state_reg    <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Source selection and post divider.
  wire [1:0] src      = act_reg[5][1:0];
  wire [2:0] pd_code  = act_reg[4][2:0];
  wire [2:0] pd_ratio = (pd_code > 3'h4) ? 3'h6 : pd_code + 3'h2;
  wire [3:0] pd_high  = {2'h0, pd_ratio[2:1]} - 4'h1;
  wire [3:0] pd_low   = {1'h0, pd_ratio} - pd_high - 4'h2;
  wire       pd_in_r  = (src == `VCD_SRC_OSC_POST) ? osc_rise : ext_rise;
  wire       pd_in_f  = (src == `VCD_SRC_OSC_POST) ? osc_fall : ext_fall;
  wire       pd_lvl   = (src == `VCD_SRC_OSC_POST) ? osc_sync_reg[2] : ext_sync_reg[2];
  wire       pd_out;
  wire       pd_rise;
  wire       pd_fall;

  vcd_divider u_post (
    .clk        (clk),
    .rst        (rst),
    .in_rise    (pd_in_r),
    .in_fall    (pd_in_f),
    .sync       (cal_sync_active),
    .bypass     (1'b0),
    .duty_cycle_correction_off (1'b0),
    .start_high (1'b0),
    .phase      (5'h00),
    .low_cnt    (pd_low),
    .high_cnt   (pd_high),
    .out_level  (pd_out),
    .out_rise   (pd_rise),
    .out_fall   (pd_fall)
  );

  wire ch_rise = (src == `VCD_SRC_EXT_DIRECT) ? ext_rise : (src != 2'h3) & pd_rise;
  wire ch_fall = (src == `VCD_SRC_EXT_DIRECT) ? ext_fall : (src != 2'h3) & pd_fall;

  // Six divider stages: 0, 1 single; 2a-2b and 3a-3b cascaded.
  wire [5:0] st_out;
  wire [5:0] st_rise;
  wire [5:0] st_fall;
  wire [5:0] st_in_r = {st_rise[4], ch_rise, st_rise[2], ch_rise, ch_rise, ch_rise};
  wire [5:0] st_in_f = {st_fall[4], ch_fall, st_fall[2], ch_fall, ch_fall, ch_fall};
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_div
      wire [7:0] mn  = act_reg[7 + 2 * g];
      wire [7:0] ctl = act_reg[8 + 2 * g];
      vcd_divider u_div (
        .clk        (clk),
        .rst        (rst),
        .in_rise    (st_in_r[g]),
        .in_fall    (st_in_f[g]),
        .sync       (cal_sync_active),
        .bypass     (ctl[`VCD_CTL_BYPASS_BIT]),
        .duty_cycle_correction_off (ctl[`VCD_CTL_CORR_OFF_BIT]),
        .start_high (ctl[`VCD_CTL_START_BIT]),
        .phase      (ctl[4:0]),
        .low_cnt    (mn[7:4]),
        .high_cnt   (mn[3:0]),
        .out_level  (st_out[g]),
        .out_rise   (st_rise[g]),
        .out_fall   (st_fall[g])
      );
    end
  endgenerate

  // Output registers with direct routing of the post divider input.
  wire route_ok = (src != `VCD_SRC_EXT_DIRECT) && (src != 2'h3) && !cal_sync_active;
  wire first_v  = (route_ok && act_reg[6][0]) ? pd_lvl : st_out[0];
  wire second_v = (route_ok && act_reg[6][1]) ? pd_lvl : st_out[1];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      diff_output_first_a  <= 1'b0;
      diff_output_first_b  <= 1'b0;
      diff_output_second_a <= 1'b0;
      diff_output_second_b <= 1'b0;
      chan2_out            <= 1'b0;
      chan3_out            <= 1'b0;
    end else begin
      diff_output_first_a  <= first_v;
      diff_output_first_b  <= first_v;
      diff_output_second_a <= second_v;
      diff_output_second_b <= second_v;
      chan2_out            <= st_out[3];
      chan3_out            <= st_out[5];
    end
  end
endmodule // vcd_clock_gen
`default_nettype wire

/* rtl/vcd_defines.vh */
`ifndef VCD_DEFINES_VH
`define VCD_DEFINES_VH
// Register indexes; the AXI byte address is four times the index.
`define VCD_IDX_RDIV_LO     10'h011
`define VCD_IDX_RDIV_HI     10'h012
`define VCD_IDX_CAL_CTRL    10'h018
`define VCD_IDX_STATUS      10'h01F
`define VCD_IDX_LOOP_CTRL   10'h0F0
`define VCD_IDX_POST_DIV    10'h1E0
`define VCD_IDX_SRC_SEL     10'h1E1
`define VCD_IDX_ROUTE       10'h1E2
`define VCD_IDX_UPDATE      10'h232
`define VCD_IDX_DIV0_MN     10'h190
`define VCD_IDX_DIV0_CTL    10'h191
`define VCD_IDX_DIV1_MN     10'h196
`define VCD_IDX_DIV1_CTL    10'h197
`define VCD_IDX_DIV2A_MN    10'h199
`define VCD_IDX_DIV2A_CTL   10'h19A
`define VCD_IDX_DIV2B_MN    10'h19B
`define VCD_IDX_DIV2B_CTL   10'h19C
`define VCD_IDX_DIV3A_MN    10'h19E
`define VCD_IDX_DIV3A_CTL   10'h19F
`define VCD_IDX_DIV3B_MN    10'h1A0
`define VCD_IDX_DIV3B_CTL   10'h1A1
// Field positions.
`define VCD_CAL_START_BIT   0
`define VCD_CAL_DIV_LSB     1
`define VCD_CAL_DONE_BIT    6
`define VCD_REF_OK_BIT      0
`define VCD_UPDATE_BIT      0
`define VCD_LOOP_EN_BIT     0
`define VCD_CTL_START_BIT   5
`define VCD_CTL_CORR_OFF_BIT 6
`define VCD_CTL_BYPASS_BIT  7
// Source select codes.
`define VCD_SRC_EXT_POST    2'h0
`define VCD_SRC_EXT_DIRECT  2'h1
`define VCD_SRC_OSC_POST    2'h2
// Reset values.
`define VCD_RESET_BYTE      8'h00
`define VCD_RESET_CTL       8'h80
// Timing.
`define VCD_CAL_CYCLES      13'd4400
`define VCD_CLK_PERIOD_NS   100
`define VCD_REF_LOSS_NS     100000
`define VCD_REF_LOSS_CYCLES (`VCD_REF_LOSS_NS / `VCD_CLK_PERIOD_NS)
`endif

/* rtl/vcd_divider.v */
`timescale 1ns/1ps
`default_nettype none
// One channel divider stage working on rise and fall pulses of its input.
module vcd_divider (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Input clock events
  input  wire       in_rise,
  input  wire       in_fall,
  // Settings
  input  wire       sync,
  input  wire       bypass,
  input  wire       duty_cycle_correction_off,
  input  wire       start_high,
  input  wire [4:0] phase,
  input  wire [3:0] low_cnt,
  input  wire [3:0] high_cnt,
  // Output
  output reg        out_level,
  output reg        out_rise,
  output reg        out_fall
);
  reg  [3:0] cnt_reg;
  reg  [3:0] cnt_next;
  reg  [4:0] dly_reg;
  reg  [4:0] dly_next;
  reg        fall_wait_reg;
  reg        fall_wait_next;
  reg        out_next;
  wire [5:0] div_m1;
  wire [4:0] phase_eff;
  wire       odd_corr_on;

  assign div_m1    = {2'h0, high_cnt} + {2'h0, low_cnt} + 6'h01;
  assign phase_eff = ({1'h0, phase} > div_m1) ? div_m1[4:0] : phase;
  assign odd_corr_on = ~duty_cycle_correction_off &&
                       ({1'h0, low_cnt} == {1'h0, high_cnt} + 5'h01);

  always @* begin
    out_next       = out_level;
    cnt_next       = cnt_reg;
    dly_next       = dly_reg;
    fall_wait_next = fall_wait_reg;
    if (sync) begin
      out_next       = start_high;
      cnt_next       = 4'h0;
      dly_next       = phase_eff;
      fall_wait_next = 1'b0;
    end else if (bypass) begin
      if (in_rise)
        out_next = 1'b1;
      else if (in_fall)
        out_next = 1'b0;
    end else if (in_rise && dly_reg != 5'h00) begin
      dly_next = dly_reg - 5'h01;
    end else if (in_rise && !fall_wait_reg) begin
      if (out_level) begin
        if (cnt_reg == high_cnt) begin
          if (odd_corr_on) begin
            fall_wait_next = 1'b1;
          end else begin
            out_next = 1'b0;
            cnt_next = 4'h0;
          end
        end else begin
          cnt_next = cnt_reg + 4'h1;
        end
      end else if (cnt_reg == low_cnt) begin
        out_next = 1'b1;
        cnt_next = 4'h0;
      end else begin
        cnt_next = cnt_reg + 4'h1;
      end
    end else if (in_fall && fall_wait_reg) begin
      out_next       = 1'b0;
      cnt_next       = 4'h0;
      fall_wait_next = 1'b0;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      out_level     <= 1'b0;
      out_rise      <= 1'b0;
      out_fall      <= 1'b0;
      cnt_reg       <= 4'h0;
      dly_reg       <= 5'h00;
      fall_wait_reg <= 1'b0;
    end else begin
      out_level     <= out_next;
      out_rise      <= out_next & ~out_level;
      out_fall      <= ~out_next & out_level;
      cnt_reg       <= cnt_next;
      dly_reg       <= dly_next;
      fall_wait_reg <= fall_wait_next;
    end
  end
endmodule // vcd_divider
`default_nettype wire

/* verification/vcd_clk_src.sv */
`timescale 1ns/1ps
`default_nettype none
// Clock pins seen from the far side: reference, external clock and oscillator.
module vcd_clk_src #(
  parameter EXT_HALF = 2
) (
  // Clock and control
  input  wire logic clk,
  input  wire logic ref_on,
  // Pins
  output var  logic ref_clk,
  output var  logic ext_clk,
  output var  logic osc_clk
);
  integer ecnt;
  initial begin
    ref_clk = 1'h0;
    ext_clk = 1'h0;
    osc_clk = 1'h0;
    ecnt = 0;
  end
  // Reference toggles each cycle while present and sits low when removed.
  always @(posedge clk) begin
    ref_clk <= ref_on ? ~ref_clk : 1'h0;
    osc_clk <= ~osc_clk;
  end
  // External clock stays far below the divider limit, so no post divider is needed.
  always @(posedge clk) begin
    ecnt <= (ecnt == EXT_HALF - 1) ? 0 : ecnt + 1;
    if (ecnt == EXT_HALF - 1) ext_clk <= ~ext_clk;
  end
  // This source has no holdover, so a calibration is never disturbed by one.
endmodule // vcd_clk_src
`default_nettype wire

/* verification/vcd_clock_gen_props.sv */
`timescale 1ns/1ps
`default_nettype none
module vcd_clock_gen_props (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Bus handshakes
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Outputs and state
  input  wire logic        diff_output_first_a,
  input  wire logic        diff_output_second_a,
  input  wire logic        chan2_out,
  input  wire logic        cal_sync_active,
  input  wire logic        loop_closed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence cal_held;
    cal_sync_active [*4];
  endsequence
  a_write_answer:
    assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("late bvalid");
  a_ready_blocked:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready in b");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("late rvalid");
  a_read_release:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("rvalid stuck");
  a_sync_loop_excl:
    assert property (cal_sync_active |-> !loop_closed) else $error("loop closed in sync");
  a_loop_after_sync:
    assert property ($fell(cal_sync_active) |=> loop_closed) else $error("loop not closed");
  a_cal_min_len:
    assert property ($rose(cal_sync_active) |=> cal_sync_active [*8]) else $error("short cal");
  a_outputs_held:
    assert property (cal_held |-> $stable({diff_output_first_a, diff_output_second_a, chan2_out}))
      else $error("outputs moved in sync");
endmodule // vcd_clock_gen_props
bind vcd_clock_gen vcd_clock_gen_props u_props (.*);
`default_nettype wire

/* verification/vcd_clock_gen_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vcd_defines.vh"
module vcd_clock_gen_test;
  logic clk, rst, ref_on, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, d;
  wire  logic  ref_clk, ext_clk, osc_clk, awready, wready, bvalid, arready, rvalid;
  wire  logic  o0a, o0b, o1a, o1b, c2, c3, sync, lc;
  wire  logic [1:0]  bresp, rresp;
  wire  logic [31:0] rdata;
  integer err_count, total_checks, seed, k, h, l, m, n;
  vcd_clk_src src_u (.clk(clk), .ref_on(ref_on), .ref_clk(ref_clk), .ext_clk(ext_clk),
    .osc_clk(osc_clk));
  vcd_clock_gen #(.REF_LOSS_CYCLES(50)) dut_u (.clk(clk), .rst(rst),
    .reference_input_clock(ref_clk), .ext_clk_in(ext_clk), .osc_clk_in(osc_clk),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .diff_output_first_a(o0a), .diff_output_first_b(o0b), .diff_output_second_a(o1a),
    .diff_output_second_b(o1b), .chan2_out(c2), .chan3_out(c3), .cal_sync_active(sync),
    .loop_closed(lc));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task tally_and_finish;
    begin
      $display("Checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("Error %s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask
  task hang(input string nm);
    begin
      chk(nm, 1, 0);
      tally_and_finish;
    end
  endtask
  task automatic axw(input logic [9:0] i, input logic [7:0] v, input logic [1:0] er);
    integer t;
    logic ta, tw, b;
    logic [1:0] r;
    begin
      @(posedge clk);
      awaddr <= {i, 2'h0};
      wdata <= {24'h000000, v};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      b = 1'h0;
      r = 2'h3;
      for (t = 0; t < 50 && !b; t = t + 1) begin
        @(negedge clk);
        ta = awvalid & awready;
        tw = wvalid & wready;
        b = (bvalid === 1'h1);
        r = bresp;
        @(posedge clk);
        if (ta) awvalid <= 1'h0;
        if (tw) wvalid <= 1'h0;
        if (b) bready <= 1'h0;
      end
      if (!b) hang("bvalid_wait");
      chk("bresp", er, r);
    end
  endtask
  task automatic axr(input logic [9:0] i, input logic [1:0] er, output logic [31:0] dv);
    integer t;
    logic ta, b;
    logic [1:0] r;
    begin
      @(posedge clk);
      araddr <= {i, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
      b = 1'h0;
      for (t = 0; t < 50 && !b; t = t + 1) begin
        @(negedge clk);
        ta = arvalid & arready;
        b = (rvalid === 1'h1);
        r = rresp;
        dv = rdata;
        @(posedge clk);
        if (ta) arvalid <= 1'h0;
        if (b) rready <= 1'h0;
      end
      if (!b) hang("rvalid_wait");
      chk("rresp", er, r);
    end
  endtask
  task upd;
    begin
      axw(`VCD_IDX_UPDATE, 8'h01, 2'h0);
      repeat (4) @(posedge clk);
    end
  endtask
  task cal_run(input integer r, input integer c);
    integer t, e;
    begin
      for (t = 0; t < 20 && sync !== 1'h1; t = t + 1) @(negedge clk);
      chk("sync_on", 1, sync);
      axr(`VCD_IDX_STATUS, 2'h0, d);
      chk("done_low", 0, d[`VCD_CAL_DONE_BIT]);
      chk("sync_static", 0, {o0a, o0b, o1a, o1b, c2, c3});
      e = 8800 * r * (2 << c);
      for (t = 0; t < e + 500 && sync === 1'h1; t = t + 1) @(negedge clk);
      chk("cal_len_ok", 1, (t > e - 40) && (t < e + 40));
      repeat (2) @(negedge clk);
      chk("loop_closed", 1, lc);
      axr(`VCD_IDX_STATUS, 2'h0, d);
      chk("done_high", 1, d[`VCD_CAL_DONE_BIT]);
    end
  endtask
  task lev(input logic v, output integer c);
    begin
      c = 0;
      while (o0a === v && c < 500) begin
        @(negedge clk);
        c = c + 1;
      end
      if (c >= 500) hang("divider_wait");
    end
  endtask
  task div_run(input integer mm, input integer nn, input logic [7:0] ctl);
    begin
      axw(`VCD_IDX_DIV0_MN, {mm[3:0], nn[3:0]}, 2'h0);
      axw(`VCD_IDX_DIV0_CTL, ctl, 2'h0);
      upd;
      lev(1'h1, h);
      lev(1'h0, h);
      lev(1'h1, h);
      lev(1'h0, l);
    end
  endtask
  initial begin
    err_count = 0;
    total_checks = 0;
    seed = 65;
    rst = 1'h1;
    ref_on = 1'h1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    axr(`VCD_IDX_CAL_CTRL, 2'h0, d);
    chk("cal_ctrl_reset", 0, d);
    axw(10'h3FF, 8'h55, 2'h2);
    axr(10'h3FF, 2'h2, d);
    chk("unmapped_data", 0, d);
    axw(`VCD_IDX_RDIV_LO, 8'h01, 2'h0);
    axw(`VCD_IDX_RDIV_HI, 8'h00, 2'h0);
    axw(`VCD_IDX_LOOP_CTRL, 8'h01, 2'h0);
    axw(`VCD_IDX_CAL_CTRL, 8'h03, 2'h0);
    repeat (20) @(negedge clk);
    chk("sync_before_update", 0, sync);
    upd;
    cal_run(1, 1);
    axw(`VCD_IDX_RDIV_LO, 8'h02, 2'h0);
    axw(`VCD_IDX_CAL_CTRL, 8'h01, 2'h0);
    upd;
    repeat (50) @(negedge clk);
    chk("no_self_cal", 0, sync);
    axw(`VCD_IDX_CAL_CTRL, 8'h00, 2'h0);
    upd;
    axw(`VCD_IDX_CAL_CTRL, 8'h01, 2'h0);
    ref_on <= 1'h0;
    upd;
    repeat (200) @(negedge clk);
    chk("pend_no_ref", 1, sync & ~lc);
    ref_on <= 1'h1;
    cal_run(2, 0);
    axw(`VCD_IDX_SRC_SEL, {6'h00, `VCD_SRC_EXT_DIRECT}, 2'h0);
    for (k = 0; k < 3; k = k + 1) begin
      m = $random(seed) & 7;
      n = $random(seed) & 7;
      div_run(m, n, 8'h40);
      chk("high_time", (n + 1) * 4, h);
      chk("low_time", (m + 1) * 4, l);
    end
    div_run(2, 1, 8'h00);
    chk("corr_high", 10, h);
    chk("corr_low", 10, l);
    axw(`VCD_IDX_ROUTE, 8'h01, 2'h0);
    div_run(2, 1, 8'h00);
    chk("route_ignored", 10, h);
    axw(`VCD_IDX_SRC_SEL, {6'h00, `VCD_SRC_EXT_POST}, 2'h0);
    div_run(0, 0, 8'h40);
    chk("route_high", 2, h);
    chk("route_low", 2, l);
    axw(`VCD_IDX_ROUTE, 8'h00, 2'h0);
    axw(`VCD_IDX_POST_DIV, 8'h01, 2'h0);
    div_run(0, 0, 8'h40);
    chk("post_high", 12, h);
    chk("post_low", 12, l);
    tally_and_finish;
  end
endmodule // vcd_clock_gen_test
`default_nettype wire
